// file: verification/adc_output_config_registers_tb_top.sv
// Self-checking bench for the output configuration register bank.
// Assumes the bank answers reads one cycle after the strobe, outputs two edges after a write.
`timescale 1ns/10ps
`default_nettype none
module adc_output_config_registers_tb_top
   import outcfg_pkg::*;
;
   logic              sys_clk;
   logic              arst_n;
   logic [7:0]        reg_addr;
   logic [15:0]       reg_wdata;
   logic              reg_wr;
   logic              reg_rd;
   logic [15:0]       reg_rdata;
   logic              dual_pattern_mode;
   logic              sample_tick;
   logic [11:0]       pattern_code_out;
   logic [9:0]        pattern_code_first;
   logic [11:0]       pattern_code_second;
   logic [15:0]       channel_order;
   logic              global_filter_enable;
   logic              averaging_enable;
   logic [31:0]       channel_gain;
   logic [15:0]       output_average_select;
   logic [15:0]       mdl [256];
   logic [31:0]       seed;
   int                fail_count;
   int                comparisons;

   adc_output_config_registers dut (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .dual_pattern_mode(dual_pattern_mode), .sample_tick(sample_tick),
      .pattern_code_out(pattern_code_out), .pattern_code_first(pattern_code_first),
      .pattern_code_second(pattern_code_second), .channel_order(channel_order),
      .global_filter_enable(global_filter_enable), .averaging_enable(averaging_enable),
      .channel_gain(channel_gain), .output_average_select(output_average_select));

   ////////////////////////////////////////////////////////////////////////////////
   // Clock, 25 ns period
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // Fixed-seed shift register keeps runs repeatable
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Writable bits per offset; unmapped places keep nothing
   function automatic logic [15:0] mask_of(input logic [7:0] a);
      case (a)
         OFS_PATTERN_ONE, OFS_PATTERN_TWO: return MASK_PATTERN;
         OFS_BIT_ORDER:                    return MASK_ORDER;
         OFS_GLOBAL_EN:                    return MASK_GLOBAL;
         OFS_GAIN_LOW, OFS_GAIN_HIGH:      return MASK_GAIN;
         OFS_AVG_LOW, OFS_AVG_HIGH:        return MASK_AVG;
         OFS_PATTERN_MSB:                  return MASK_PAT_MSB;
         default:                          return 16'h0000;
      endcase
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic conclude;
      $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Bus cycles; one idle edge between strobes avoids double assignment
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      mdl[a] = d & mask_of(a);
   endtask

   task automatic rd_chk(input logic [7:0] a);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk(32'(reg_rdata), 32'(mdl[a]));
   endtask

   // Expected static outputs worked out from the stored words
   task automatic check_outputs;
      logic [15:0] o;
      logic [15:0] e_ord;
      logic [15:0] e_av;
      logic [15:0] e_gh;
      logic [11:0] e_sec;
      o = mdl[OFS_BIT_ORDER];
      repeat (3) @(posedge sys_clk);
      #1;
      for (int i = 0; i < 8; i++) begin
         if (!o[15]) e_ord[2*i+:2] = 2'd0;
         else if (o[i]) e_ord[2*i+:2] = 2'd1;
         else if (o[8]) e_ord[2*i+:2] = 2'd2;
         else e_ord[2*i+:2] = 2'd0;
      end
      for (int i = 0; i < 4; i++) begin
         e_av[2*i+:2] = mdl[OFS_AVG_LOW][3*i+:2];
         e_av[8+2*i+:2] = mdl[OFS_AVG_HIGH][3*i+:2];
         // Channel five owns the top nibble, channel eight the bottom one
         e_gh[4*i+:4] = mdl[OFS_GAIN_HIGH][12-4*i+:4];
      end
      e_sec = {mdl[OFS_PATTERN_MSB][3:2], mdl[OFS_PATTERN_TWO][15:6]};
      chk(32'(pattern_code_first), 32'(mdl[OFS_PATTERN_ONE][15:6]));
      chk(32'(pattern_code_second), 32'(e_sec));
      chk(32'(channel_order), 32'(e_ord));
      chk(32'(global_filter_enable), 32'(mdl[OFS_GLOBAL_EN][1]));
      chk(32'(averaging_enable), 32'(mdl[OFS_GLOBAL_EN][0]));
      chk(32'(channel_gain[15:0]), 32'(mdl[OFS_GAIN_LOW]));
      chk(32'(channel_gain[31:16]), 32'(e_gh));
      chk(32'(output_average_select), 32'(e_av));
   endtask

   task automatic tick_chk(input logic [11:0] exp);
      @(posedge sys_clk);
      sample_tick <= 1'b1;
      @(posedge sys_clk);
      sample_tick <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      chk(32'(pattern_code_out), 32'(exp));
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      logic [11:0] c1;
      logic [11:0] c2;
      fail_count = 0;
      comparisons = 0;
      seed = 32'h7032_3487;
      for (int i = 0; i < 256; i++) mdl[i] = 16'h0000;
      // High first, so the reset fall is a real edge for every process
      arst_n = 1'b1;
      {reg_wr, reg_rd, dual_pattern_mode, sample_tick} = 4'h0;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      #1 arst_n = 1'b0;
      repeat (6) @(posedge sys_clk);
      arst_n <= 1'b1;
      for (int a = 8'h24; a <= 8'h2e; a++) rd_chk(a[7:0]);
      check_outputs();
      // Random words, reserved bits kept zero, to every place and a few unmapped
      for (int r = 0; r < 6; r++) begin
         for (int a = 8'h24; a <= 8'h2e; a++) begin
            seed = lfsr_next(seed);
            wr(a[7:0], seed[15:0] & mask_of(a[7:0]));
         end
         wr(8'h00, 16'hffff);
         for (int a = 8'h24; a <= 8'h2e; a++) rd_chk(a[7:0]);
         rd_chk(8'h00);
         check_outputs();
      end
      // Every bit-order case: enable off/on, bit-wise off/on, channel bits mixed
      for (int m = 0; m < 4; m++) begin
         seed = lfsr_next(seed);
         wr(OFS_BIT_ORDER, {m[1], 6'h00, m[0], seed[7:0]});
         check_outputs();
      end
      wr(OFS_BIT_ORDER, 16'h8100);
      check_outputs();
      wr(OFS_BIT_ORDER, 16'h80ff);
      check_outputs();
      // Pattern sequencing: single holds first code, dual alternates
      c1 = {2'b00, mdl[OFS_PATTERN_ONE][15:6]};
      c2 = {mdl[OFS_PATTERN_MSB][3:2], mdl[OFS_PATTERN_TWO][15:6]};
      tick_chk(c1);
      @(posedge sys_clk);
      dual_pattern_mode <= 1'b1;
      tick_chk(c2);
      tick_chk(c1);
      tick_chk(c2);
      @(posedge sys_clk);
      dual_pattern_mode <= 1'b0;
      tick_chk(c1);
      // Reset in mid-run clears every word again
      @(posedge sys_clk);
      arst_n <= 1'b0;
      repeat (6) @(posedge sys_clk);
      arst_n <= 1'b1;
      for (int i = 0; i < 256; i++) mdl[i] = 16'h0000;
      for (int a = 8'h24; a <= 8'h2e; a++) rd_chk(a[7:0]);
      check_outputs();
      conclude();
   end

   // Watchdog far beyond the roughly four hundred cycles the sequence needs
   initial begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      conclude();
   end
endmodule
`default_nettype wire

// file: verilog/adc_output_config_registers.sv
// Output path configuration bank: patterns, bit order, filter, gain, averaging.
// Assumes a synchronous register port; read data valid one cycle after strobe.
//
// How it works
// - First pattern code low ten bits come from bits 15..6 of word 0x26.
// - Second pattern code low ten bits come from bits 15..6 of 0x27.
// - Bit order word clears to zero on reset.
// - Order enable clear gives byte-wise serialization in two-wire mode.
// - Order enable set and channel bit one gives word-wise order.
// - Order enable and bit-wise enable set, channel bit zero gives bit-wise.
// - Global filter enable at bit 1, off by default.
// - Averaging enable at bit 0, off by default, applies per-output selectors.
// - Gains for channels 4..1 sit at nibbles 15..12 down to 3..0.
// - Gains for channels 5..8 sit at nibbles 15..12 down to 3..0.
// - Outputs 1..4 averaging selectors at bits 1:0, 4:3, 7:6, 10:9.
// - Outputs 5..8 averaging selectors at bits 1:0, 4:3, 7:6, 10:9.
// - Second code top two bits come from a separate 2-bit field.
// - Dual pattern alternates codes; single pattern holds the first code.
`timescale 1ns/10ps
`default_nettype none
module adc_output_config_registers
   import outcfg_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              arst_n,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [DATA_W-1:0]      reg_rdata,
   input  wire logic              dual_pattern_mode,
   input  wire logic              sample_tick,
   output logic [11:0]            pattern_code_out,
   output logic [9:0]             pattern_code_first,
   output logic [11:0]            pattern_code_second,
   output logic [NUM_CH*2-1:0]    channel_order,
   output logic                   global_filter_enable,
   output logic                   averaging_enable,
   output logic [NUM_CH*GAIN_W-1:0] channel_gain,
   output logic [NUM_CH*AVG_W-1:0]  output_average_select
);

   ////////////////////////////////////////////////////////////////////////
   // Register storage
   ////////////////////////////////////////////////////////////////////////
   cfg_bus_if bus ();
   assign bus.wr_en = reg_wr;
   assign bus.addr  = reg_addr;
   assign bus.wdata = reg_wdata;

   logic [15:0] pat_one;
   logic [15:0] pat_two;
   logic [15:0] pat_msb;
   logic [15:0] order_w;
   logic [15:0] glob_w;
   logic [15:0] gain_lo;
   logic [15:0] gain_hi;
   logic [15:0] avg_lo;
   logic [15:0] avg_hi;

   // Reserved bits masked so a careless write cannot leak into the path
   cfg_word_reg #(.OFFSET(OFS_PATTERN_ONE), .MASK(MASK_PATTERN)) u_pat1 (
      .sys_clk(sys_clk), .arst_n(arst_n), .bus(bus), .value(pat_one));
   cfg_word_reg #(.OFFSET(OFS_PATTERN_TWO), .MASK(MASK_PATTERN)) u_pat2 (
      .sys_clk(sys_clk), .arst_n(arst_n), .bus(bus), .value(pat_two));
   cfg_word_reg #(.OFFSET(OFS_PATTERN_MSB), .MASK(MASK_PAT_MSB)) u_patm (
      .sys_clk(sys_clk), .arst_n(arst_n), .bus(bus), .value(pat_msb));
   cfg_word_reg #(.OFFSET(OFS_BIT_ORDER), .MASK(MASK_ORDER)) u_order (
      .sys_clk(sys_clk), .arst_n(arst_n), .bus(bus), .value(order_w));
   cfg_word_reg #(.OFFSET(OFS_GLOBAL_EN), .MASK(MASK_GLOBAL)) u_glob (
      .sys_clk(sys_clk), .arst_n(arst_n), .bus(bus), .value(glob_w));
   cfg_word_reg #(.OFFSET(OFS_GAIN_LOW), .MASK(MASK_GAIN)) u_gain_lo (
      .sys_clk(sys_clk), .arst_n(arst_n), .bus(bus), .value(gain_lo));
   cfg_word_reg #(.OFFSET(OFS_GAIN_HIGH), .MASK(MASK_GAIN)) u_gain_hi (
      .sys_clk(sys_clk), .arst_n(arst_n), .bus(bus), .value(gain_hi));
   cfg_word_reg #(.OFFSET(OFS_AVG_LOW), .MASK(MASK_AVG)) u_avg_lo (
      .sys_clk(sys_clk), .arst_n(arst_n), .bus(bus), .value(avg_lo));
   cfg_word_reg #(.OFFSET(OFS_AVG_HIGH), .MASK(MASK_AVG)) u_avg_hi (
      .sys_clk(sys_clk), .arst_n(arst_n), .bus(bus), .value(avg_hi));

   ////////////////////////////////////////////////////////////////////////
   // Read path
   ////////////////////////////////////////////////////////////////////////
   // Unmapped addresses read zero
   logic [15:0] rd_mux;
   always_comb begin
      case (reg_addr)
         OFS_PATTERN_ONE: rd_mux = pat_one;
         OFS_PATTERN_TWO: rd_mux = pat_two;
         OFS_PATTERN_MSB: rd_mux = pat_msb;
         OFS_BIT_ORDER:   rd_mux = order_w;
         OFS_GLOBAL_EN:   rd_mux = glob_w;
         OFS_GAIN_LOW:    rd_mux = gain_lo;
         OFS_GAIN_HIGH:   rd_mux = gain_hi;
         OFS_AVG_LOW:     rd_mux = avg_lo;
         OFS_AVG_HIGH:    rd_mux = avg_hi;
         default:         rd_mux = RST_VALUE;
      endcase
   end

   // Data stands only in the cycle after the strobe
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= RST_VALUE;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : RST_VALUE;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Field decode
   ////////////////////////////////////////////////////////////////////////
   wire        order_en  = order_w[ORDER_EN_POS];
   wire        bit_wise  = order_w[BIT_WISE_POS];
   wire [9:0]  code1_nxt = pat_one[15:PAT_LSB];
   wire [11:0] code2_nxt = {pat_msb[PAT_MSB_POS+1:PAT_MSB_POS], pat_two[15:PAT_LSB]};
   wire [11:0] code1_ext = {2'b00, code1_nxt};

   logic [NUM_CH*2-1:0]      order_nxt;
   logic [NUM_CH*GAIN_W-1:0] gain_nxt;
   logic [NUM_CH*AVG_W-1:0]  avg_nxt;

   // Per channel order, gain and averaging selector
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
         order_mode_t m;
         // Word-wise wins over bit-wise for a channel whose select bit is one
         assign m = !order_en ? ORDER_BYTE :
                    order_w[ch] ? ORDER_WORD :
                    bit_wise ? ORDER_BIT : ORDER_BYTE;
         assign order_nxt[ch*2 +: 2] = m;
         // Low bank counts up from nibble 0, high bank counts down from nibble 3
         if (ch < 4) begin : g_lo
            assign gain_nxt[ch*GAIN_W +: GAIN_W] = gain_lo[ch*GAIN_W +: GAIN_W];
            assign avg_nxt[ch*AVG_W +: AVG_W] = avg_lo[ch*AVG_STRIDE +: AVG_W];
         end else begin : g_hi
            assign gain_nxt[ch*GAIN_W +: GAIN_W] = gain_hi[(7-ch)*GAIN_W +: GAIN_W];
            assign avg_nxt[ch*AVG_W +: AVG_W] = avg_hi[(ch-4)*AVG_STRIDE +: AVG_W];
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Pattern sequencer
   ////////////////////////////////////////////////////////////////////////
   // Phase flips on each sample tick; held at first code in single mode
   logic phase_r;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         phase_r <= 1'b0;
      end else if (!dual_pattern_mode) begin
         phase_r <= 1'b0;
      end else if (sample_tick) begin
         phase_r <= ~phase_r;
      end
   end

   wire [11:0] pattern_nxt = phase_r ? code2_nxt : code1_ext;

   ////////////////////////////////////////////////////////////////////////
   // Registered outputs
   ////////////////////////////////////////////////////////////////////////
   // One stage of flops keeps every output glitch-free toward the data path
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pattern_code_out      <= '0;
         pattern_code_first    <= '0;
         pattern_code_second   <= '0;
         channel_order         <= '0;
         global_filter_enable  <= 1'b0;
         averaging_enable      <= 1'b0;
         channel_gain          <= '0;
         output_average_select <= '0;
      end else begin
         pattern_code_out      <= pattern_nxt;
         pattern_code_first    <= code1_nxt;
         pattern_code_second   <= code2_nxt;
         channel_order         <= order_nxt;
         global_filter_enable  <= glob_w[FILTER_EN_POS];
         averaging_enable      <= glob_w[AVG_EN_POS];
         channel_gain          <= gain_nxt;
         output_average_select <= avg_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   ////////////////////////////////////////////////////////////////////////
   // Field outputs land two edges after the write edge, hence the two-cycle look back
   chk_pattern_first_low: assert property (@(posedge sys_clk) disable iff (!arst_n)
      reg_wr && reg_addr == OFS_PATTERN_ONE
      |=> ##1 pattern_code_first == $past(reg_wdata[15:6], 2))
      else $error("first pattern code mismatch");
   chk_pattern_second_low: assert property (@(posedge sys_clk) disable iff (!arst_n)
      reg_wr && reg_addr == OFS_PATTERN_TWO
      |=> ##1 pattern_code_second[9:0] == $past(reg_wdata[15:6], 2))
      else $error("second pattern code mismatch");
   chk_pattern_msb: assert property (@(posedge sys_clk) disable iff (!arst_n)
      reg_wr && reg_addr == OFS_PATTERN_MSB
      |=> ##1 pattern_code_second[11:10] == $past(reg_wdata[3:2], 2))
      else $error("second pattern top bits mismatch");
   // Reserved bits must never reach storage, whatever software writes
   chk_pattern_reserved: assert property (@(posedge sys_clk) disable iff (!arst_n)
      pat_one[PAT_LSB-1:0] == '0
      && pat_two[PAT_LSB-1:0] == '0)
      else $error("pattern reserved bits stored");
   chk_global_reserved: assert property (@(posedge sys_clk) disable iff (!arst_n)
      glob_w[DATA_W-1:FILTER_EN_POS+1] == '0)
      else $error("global enable reserved bits stored");
   // Per-channel order: channel one sits at [1:0], channel eight at [15:14]
   chk_order_byte_mode: assert property (@(posedge sys_clk) disable iff (!arst_n)
      !order_w[ORDER_EN_POS]
      |=> channel_order == '0)
      else $error("byte order expected");
   chk_order_word_mode: assert property (@(posedge sys_clk) disable iff (!arst_n)
      order_w[ORDER_EN_POS] && order_w[0]
      |=> channel_order[1:0] == ORDER_WORD)
      else $error("word order expected on channel one");
   chk_order_word_last: assert property (@(posedge sys_clk) disable iff (!arst_n)
      order_w[ORDER_EN_POS] && order_w[7]
      |=> channel_order[15:14] == ORDER_WORD)
      else $error("word order expected on channel eight");
   chk_order_bit_mode: assert property (@(posedge sys_clk) disable iff (!arst_n)
      order_w[ORDER_EN_POS] && order_w[BIT_WISE_POS] && !order_w[7]
      |=> channel_order[15:14] == ORDER_BIT)
      else $error("bit order expected on channel eight");
   chk_order_bit_first: assert property (@(posedge sys_clk) disable iff (!arst_n)
      order_w[ORDER_EN_POS] && order_w[BIT_WISE_POS] && !order_w[0]
      |=> channel_order[1:0] == ORDER_BIT)
      else $error("bit order expected on channel one");
   chk_filter_enable: assert property (@(posedge sys_clk) disable iff (!arst_n)
      reg_wr && reg_addr == OFS_GLOBAL_EN
      |=> ##1 global_filter_enable == $past(reg_wdata[1], 2))
      else $error("filter enable mismatch");
   chk_avg_enable: assert property (@(posedge sys_clk) disable iff (!arst_n)
      reg_wr && reg_addr == OFS_GLOBAL_EN
      |=> ##1 averaging_enable == $past(reg_wdata[0], 2))
      else $error("averaging enable mismatch");
   // Gain and selector fields pass raw, so they equal the written bits
   chk_gain_ch_one: assert property (@(posedge sys_clk) disable iff (!arst_n)
      reg_wr && reg_addr == OFS_GAIN_LOW
      |=> ##1 channel_gain[3:0] == $past(reg_wdata[3:0], 2))
      else $error("channel one gain mismatch");
   chk_gain_ch_four: assert property (@(posedge sys_clk) disable iff (!arst_n)
      reg_wr && reg_addr == OFS_GAIN_LOW
      |=> ##1 channel_gain[15:12] == $past(reg_wdata[15:12], 2))
      else $error("channel four gain mismatch");
   chk_gain_ch_five: assert property (@(posedge sys_clk) disable iff (!arst_n)
      reg_wr && reg_addr == OFS_GAIN_HIGH
      |=> ##1 channel_gain[19:16] == $past(reg_wdata[15:12], 2))
      else $error("channel five gain mismatch");
   chk_gain_ch_eight: assert property (@(posedge sys_clk) disable iff (!arst_n)
      reg_wr && reg_addr == OFS_GAIN_HIGH
      |=> ##1 channel_gain[31:28] == $past(reg_wdata[3:0], 2))
      else $error("channel eight gain mismatch");
   chk_avg_out_one: assert property (@(posedge sys_clk) disable iff (!arst_n)
      reg_wr && reg_addr == OFS_AVG_LOW
      |=> ##1 output_average_select[1:0] == $past(reg_wdata[1:0], 2))
      else $error("output one selector mismatch");
   chk_avg_out_four: assert property (@(posedge sys_clk) disable iff (!arst_n)
      reg_wr && reg_addr == OFS_AVG_LOW
      |=> ##1 output_average_select[7:6] == $past(reg_wdata[10:9], 2))
      else $error("output four selector mismatch");
   chk_avg_out_five: assert property (@(posedge sys_clk) disable iff (!arst_n)
      reg_wr && reg_addr == OFS_AVG_HIGH
      |=> ##1 output_average_select[9:8] == $past(reg_wdata[1:0], 2))
      else $error("output five selector mismatch");
   chk_avg_out_seven: assert property (@(posedge sys_clk) disable iff (!arst_n)
      reg_wr && reg_addr == OFS_AVG_HIGH
      |=> ##1 output_average_select[13:12] == $past(reg_wdata[7:6], 2))
      else $error("output seven selector mismatch");
   chk_avg_out_eight: assert property (@(posedge sys_clk) disable iff (!arst_n)
      reg_wr && reg_addr == OFS_AVG_HIGH
      |=> ##1 output_average_select[15:14] == $past(reg_wdata[10:9], 2))
      else $error("output eight selector mismatch");
   // Phase flips on a tick in dual mode and clears in single mode; code and output flops move together
   chk_phase_toggles: assert property (@(posedge sys_clk) disable iff (!arst_n)
      dual_pattern_mode && sample_tick
      |=> phase_r != $past(phase_r))
      else $error("pattern phase did not flip");
   chk_phase_cleared: assert property (@(posedge sys_clk) disable iff (!arst_n)
      !dual_pattern_mode
      |=> !phase_r)
      else $error("pattern phase not cleared");
   chk_second_code_out: assert property (@(posedge sys_clk) disable iff (!arst_n)
      phase_r
      |=> pattern_code_out == pattern_code_second)
      else $error("second pattern code not sent");
   chk_single_holds_first: assert property (@(posedge sys_clk) disable iff (!arst_n)
      !dual_pattern_mode [*2]
      |=> pattern_code_out == {2'b00, pattern_code_first})
      else $error("single pattern not constant");
   // Read data stands one cycle after the strobe and is zero otherwise
   chk_read_gain_path: assert property (@(posedge sys_clk) disable iff (!arst_n)
      reg_rd && reg_addr == OFS_GAIN_LOW
      |=> reg_rdata == channel_gain[15:0])
      else $error("gain read differs from gain output");
   chk_rdata_idle_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
      !reg_rd
      |=> reg_rdata == '0)
      else $error("read data without strobe");
   // Reset checks carry no disable so they watch the reset itself
   chk_order_reset_zero: assert property (@(posedge sys_clk)
      !arst_n
      |-> order_w == '0)
      else $error("order word not cleared");
   chk_order_out_reset: assert property (@(posedge sys_clk)
      !arst_n
      |-> channel_order == '0)
      else $error("order output not cleared");
   chk_enables_reset: assert property (@(posedge sys_clk)
      !arst_n
      |-> !global_filter_enable && !averaging_enable)
      else $error("global enables not cleared");

endmodule
`default_nettype wire

// file: verilog/cfg_bus_if.sv
// Write port carrier between the register port and the register storage.
// Assumes one clock domain; no clocking block.
`timescale 1ns/10ps
`default_nettype none
interface cfg_bus_if;
   import outcfg_pkg::*;
   logic              wr_en;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   modport master (output wr_en, output addr, output wdata);
   modport slave  (input wr_en, input addr, input wdata);
endinterface
`default_nettype wire

// file: verilog/cfg_word_reg.sv
// One 16-bit configuration word with a writable mask.
// Assumes the write port carries the raw write strobe and address; each word decodes its own offset.
`timescale 1ns/10ps
`default_nettype none
module cfg_word_reg
   import outcfg_pkg::*;
#(
   parameter logic [7:0]  OFFSET = 8'h00,
   parameter logic [15:0] MASK   = 16'hffff
) (
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   cfg_bus_if.slave         bus,
   output logic [15:0]      value
);
   // Own write hit; masked bits never store so reserved bits read zero
   wire hit = bus.wr_en && (bus.addr == OFFSET);

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         value <= RST_VALUE;
      end else if (hit) begin
         value <= bus.wdata & MASK;
      end
   end
endmodule
`default_nettype wire

// file: verilog/outcfg_pkg.sv
// Shared constants for the output configuration register bank.
// Assumes a plain address/strobe register port with 16-bit data.
package outcfg_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int NUM_CH = 8;
   localparam int GAIN_W = 4;
   localparam int AVG_W  = 2;

   // Register offsets
   localparam logic [7:0] OFS_PATTERN_ONE  = 8'h26;
   localparam logic [7:0] OFS_PATTERN_TWO  = 8'h27;
   localparam logic [7:0] OFS_BIT_ORDER    = 8'h28;
   localparam logic [7:0] OFS_GLOBAL_EN    = 8'h29;
   localparam logic [7:0] OFS_GAIN_LOW     = 8'h2a;
   localparam logic [7:0] OFS_GAIN_HIGH    = 8'h2b;
   localparam logic [7:0] OFS_AVG_LOW      = 8'h2c;
   localparam logic [7:0] OFS_AVG_HIGH     = 8'h2d;
   // Own register holding the two upper bits of the second pattern code
   localparam logic [7:0] OFS_PATTERN_MSB  = 8'h25;

   // Field positions
   localparam int PAT_LSB       = 6;
   localparam int PAT_MSB_POS   = 2;
   localparam int ORDER_EN_POS  = 15;
   localparam int BIT_WISE_POS  = 8;
   localparam int FILTER_EN_POS = 1;
   localparam int AVG_EN_POS    = 0;
   localparam int AVG_STRIDE    = 3;

   // Values after reset
   localparam logic [15:0] RST_VALUE = 16'h0000;

   // Writable masks; reserved bits store and read as zero
   localparam logic [15:0] MASK_PATTERN   = 16'hffc0;
   localparam logic [15:0] MASK_ORDER     = 16'h81ff;
   localparam logic [15:0] MASK_GLOBAL    = 16'h0003;
   localparam logic [15:0] MASK_GAIN      = 16'hffff;
   localparam logic [15:0] MASK_AVG       = 16'h06db;
   localparam logic [15:0] MASK_PAT_MSB   = 16'h000c;

   typedef enum logic [1:0] {
      ORDER_BYTE,
      ORDER_WORD,
      ORDER_BIT
   } order_mode_t;
endpackage
